// >>> design/simf_defines.svh
// Register map, field positions, reset values and codes of the input function mux
`ifndef SIMF_DEFINES_SVH
`define SIMF_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SIMF_OFS_CTRL    8'h00
`define SIMF_OFS_ALLOC1  8'h04
`define SIMF_OFS_ALLOC2  8'h08
`define SIMF_OFS_STATUS  8'h0C

// ----------------------------------------------------------------
// Field positions, four bits each
// ----------------------------------------------------------------
`define SIMF_F_METHOD    0
`define SIMF_F_MODE      0
`define SIMF_F_SON       4
`define SIMF_F_PCON      8
`define SIMF_F_POT       12
`define SIMF_F_NOT       0
`define SIMF_F_ALM       4
`define SIMF_F_PCL       8
`define SIMF_F_NCL       12

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define SIMF_S_BASEBLOCK 0
`define SIMF_S_MONITOR   1
`define SIMF_S_SAFE_A    2
`define SIMF_S_SAFE_B    3
`define SIMF_S_PINS      8
`define SIMF_S_FUNC      16

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SIMF_RST_CTRL    4'h0
`define SIMF_RST_ALLOC1  16'h2100
`define SIMF_RST_ALLOC2  16'h6543

// ----------------------------------------------------------------
// Allocation codes and bus answers
// ----------------------------------------------------------------
`define SIMF_ALLOC_LAST_LOW 4'h6
`define SIMF_ALLOC_ON    4'h7
`define SIMF_ALLOC_OFF   4'h8
`define SIMF_ALLOC_HIGH0 4'h9
`define SIMF_MODE_USER   4'h1
`define SIMF_RESP_OKAY   2'h0
`define SIMF_RESP_SLVERR 2'h2

`endif

// >>> design/simf_pkg.sv
// Types of the input function mux
package simf_pkg;

  // ----------------------------------------------------------------
  // Control method settings
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SIMF_SPD_ANALOG  = 4'h0,
    SIMF_POS_PULSE   = 4'h1,
    SIMF_FRC_ANALOG  = 4'h2,
    SIMF_SPD_CONTACT = 4'h3,
    SIMF_CON_SPD     = 4'h4,
    SIMF_CON_POS     = 4'h5,
    SIMF_CON_FRC     = 4'h6,
    SIMF_POS_SPD     = 4'h7,
    SIMF_POS_FRC     = 4'h8,
    SIMF_FRC_SPD     = 4'h9,
    SIMF_SPD_ZERO_CLAMP_IN  = 4'hA,
    SIMF_POS_INHIBIT = 4'hB
  } simf_method_t;

  // ----------------------------------------------------------------
  // Pin levels and selected functions
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [6:0] seq;
    logic       safe_a;
    logic       safe_b;
  } simf_pins_t;

  typedef struct packed {
    logic servo_on;
    logic fwd_run_prohibit_in;
    logic rev_run_prohibit_in;
    logic alarm_clear_in;
    logic proportional_op_in;
    logic fwd_force_limit_in;
    logic rev_force_limit_in;
    logic move_direction_sel;
    logic int_speed_sel_a;
    logic int_speed_sel_b;
    logic ctrl_switch;
    logic zero_clamp_in;
    logic pulse_inhibit;
  } simf_func_t;

endpackage : simf_pkg

// >>> design/simf_sync.sv
// Two-flop synchroniser for pin levels
`timescale 1ns/1ps
module simf_sync #(
  parameter int W = 9
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_b,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // ----------------------------------------------------------------
  // First stage, read only by the second
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) meta_r <= '0;
    else meta_r <= d;
  end

  // ----------------------------------------------------------------
  // Second stage
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) q <= '0;
    else q <= meta_r;
  end

endmodule : simf_sync

// >>> design/simf_top.sv
// Input function mux, safety baseblock and AXI4-Lite register slave
//
// Operation
// - Either safety input OFF cuts motor current.
// - Monitor output ON only while both safety inputs are OFF.
// - Method change reinterprets pins; stored allocation stays untouched.
// - Methods 0-2: pin 41 proportional, 45/46 force limits.
// - Method 3: pin 41 direction, 45/46 speed select A/B.
// - Methods 4-6: pin 41 direction, 45/46 speed select A/B.
// - Methods 7-9: pin 41 method switch, 45/46 force limits.
// - Method A: pin 41 is zero clamp.
// - Method B: pin 41 is reference pulse inhibit.
// - Pins 40,42,43,44 stay servo on, prohibits and alarm clear.
// - Both allocation groups read back the current allocation.
// - Function digit changes honoured only while mode digit is 1; the mode digit itself is always writable.
// - Code 7 forces function on, code 8 forces it off.
`timescale 1ns/1ps
`include "simf_defines.svh"
module simf_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_b,
  // Sequence and safety pins
  input  wire logic [6:0]        seq_pin_on,
  input  wire logic              safety_block_in_a,
  input  wire logic              safety_block_in_b,
  // Drive side
  output logic                   current_enable,
  output logic                   safety_monitor_out,
  output simf_pkg::simf_func_t   func_out,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic alloc_level(input logic [3:0] code, input logic [6:0] pins);
    logic r;
    r = 1'h0;
    if (code <= `SIMF_ALLOC_LAST_LOW) r = pins[code[2:0]];
    else if (code == `SIMF_ALLOC_ON) r = 1'h1;
    else if (code == `SIMF_ALLOC_OFF) r = 1'h0;
    else r = ~pins[3'(code - `SIMF_ALLOC_HIGH0)];
    return r;
  endfunction : alloc_level

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] data,
                                          input logic [1:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) r[7:0] = data[7:0];
    if (strb[1]) r[15:8] = data[15:8];
    return r;
  endfunction : merge16

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  simf_pkg::simf_pins_t pins_raw;
  simf_pkg::simf_pins_t pins_s;
  simf_pkg::simf_func_t func_nxt;
  logic [3:0]           method_r;
  logic [15:0]          alloc1_r;
  logic [15:0]          alloc2_r;
  logic [15:0]          alloc1_nxt;
  logic [15:0]          alloc2_nxt;
  logic                 user_mode;
  logic                 s41;
  logic                 s45;
  logic                 s46;
  logic                 aw_got_r;
  logic                 w_got_r;
  logic [ADDR_W-1:0]    awaddr_r;
  logic [31:0]          wdata_r;
  logic [3:0]           wstrb_r;
  logic                 do_write;
  logic                 wr_ctrl;
  logic                 wr_a1;
  logic                 wr_a2;
  logic                 wr_ok;
  logic [31:0]          rd_data;
  logic                 rd_ok;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  assign pins_raw = '{seq: seq_pin_on, safe_a: safety_block_in_a, safe_b: safety_block_in_b};

  simf_sync #(
    .W ($bits(simf_pkg::simf_pins_t))
  ) u_sync (
    .clock (clock),
    .rst_b (rst_b),
    .d     (pins_raw),
    .q     (pins_s)
  );

  // ----------------------------------------------------------------
  // Function selection
  // ----------------------------------------------------------------
  assign user_mode = (alloc1_r[`SIMF_F_MODE +: 4] == `SIMF_MODE_USER);

  always_comb begin
    s41 = alloc_level(alloc1_r[`SIMF_F_PCON +: 4], pins_s.seq);
    s45 = alloc_level(alloc2_r[`SIMF_F_PCL +: 4], pins_s.seq);
    s46 = alloc_level(alloc2_r[`SIMF_F_NCL +: 4], pins_s.seq);
    func_nxt = '0;
    func_nxt.servo_on            = alloc_level(alloc1_r[`SIMF_F_SON +: 4], pins_s.seq);
    func_nxt.fwd_run_prohibit_in = alloc_level(alloc1_r[`SIMF_F_POT +: 4], pins_s.seq);
    func_nxt.rev_run_prohibit_in = alloc_level(alloc2_r[`SIMF_F_NOT +: 4], pins_s.seq);
    func_nxt.alarm_clear_in      = alloc_level(alloc2_r[`SIMF_F_ALM +: 4], pins_s.seq);
    case (simf_pkg::simf_method_t'(method_r))
      simf_pkg::SIMF_SPD_ANALOG, simf_pkg::SIMF_POS_PULSE, simf_pkg::SIMF_FRC_ANALOG: begin
        func_nxt.proportional_op_in = s41;
        func_nxt.fwd_force_limit_in = s45;
        func_nxt.rev_force_limit_in = s46;
      end
      simf_pkg::SIMF_SPD_CONTACT: begin
        func_nxt.move_direction_sel = s41;
        func_nxt.int_speed_sel_a    = s45;
        func_nxt.int_speed_sel_b    = s46;
      end
      simf_pkg::SIMF_CON_SPD, simf_pkg::SIMF_CON_POS, simf_pkg::SIMF_CON_FRC: begin
        func_nxt.move_direction_sel = s41;
        func_nxt.int_speed_sel_a    = s45;
        func_nxt.int_speed_sel_b    = s46;
      end
      simf_pkg::SIMF_POS_SPD, simf_pkg::SIMF_POS_FRC, simf_pkg::SIMF_FRC_SPD: begin
        func_nxt.ctrl_switch        = s41;
        func_nxt.fwd_force_limit_in = s45;
        func_nxt.rev_force_limit_in = s46;
      end
      simf_pkg::SIMF_SPD_ZERO_CLAMP_IN: begin
        func_nxt.zero_clamp_in      = s41;
        func_nxt.fwd_force_limit_in = s45;
        func_nxt.rev_force_limit_in = s46;
      end
      simf_pkg::SIMF_POS_INHIBIT: begin
        func_nxt.pulse_inhibit      = s41;
        func_nxt.fwd_force_limit_in = s45;
        func_nxt.rev_force_limit_in = s46;
      end
      default: begin
        func_nxt.proportional_op_in = s41;
        func_nxt.fwd_force_limit_in = s45;
        func_nxt.rev_force_limit_in = s46;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) func_out <= '0;
    else func_out <= func_nxt;
  end

  // ----------------------------------------------------------------
  // Safety baseblock
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      current_enable     <= 1'h0;
      safety_monitor_out <= 1'h0;
    end else begin
      current_enable     <= pins_s.safe_a & pins_s.safe_b;
      // both channels OFF is a normal baseblock
      safety_monitor_out <= ~pins_s.safe_a & ~pins_s.safe_b;
    end
  end

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  assign do_write = aw_got_r & w_got_r & ~s_axi_bvalid;
  assign wr_ctrl  = (awaddr_r == ADDR_W'(`SIMF_OFS_CTRL));
  assign wr_a1    = (awaddr_r == ADDR_W'(`SIMF_OFS_ALLOC1));
  assign wr_a2    = (awaddr_r == ADDR_W'(`SIMF_OFS_ALLOC2));
  assign wr_ok    = wr_ctrl | wr_a1 | wr_a2 | (awaddr_r == ADDR_W'(`SIMF_OFS_STATUS));

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aw_got_r      <= 1'h0;
      w_got_r       <= 1'h0;
      awaddr_r      <= '0;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'h1;
      s_axi_wready  <= 1'h1;
      s_axi_bvalid  <= 1'h0;
      s_axi_bresp   <= `SIMF_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r      <= 1'h1;
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r      <= 1'h1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'h0;
      end
      if (do_write) begin
        aw_got_r     <= 1'h0;
        w_got_r      <= 1'h0;
        s_axi_bvalid <= 1'h1;
        s_axi_bresp  <= wr_ok ? `SIMF_RESP_OKAY : `SIMF_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'h0;
        s_axi_awready <= 1'h1;
        s_axi_wready  <= 1'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_comb begin
    alloc1_nxt = merge16(alloc1_r, wdata_r[15:0], wstrb_r[1:0]);
    // function digits locked outside user mode
    if (!user_mode) alloc1_nxt[15:`SIMF_F_SON] = alloc1_r[15:`SIMF_F_SON];
    alloc2_nxt = user_mode ? merge16(alloc2_r, wdata_r[15:0], wstrb_r[1:0]) : alloc2_r;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) method_r <= `SIMF_RST_CTRL;
    else if (do_write && wr_ctrl && wstrb_r[0]) method_r <= wdata_r[`SIMF_F_METHOD +: 4];
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      alloc1_r <= `SIMF_RST_ALLOC1;
      alloc2_r <= `SIMF_RST_ALLOC2;
    end else if (do_write) begin
      if (wr_a1) alloc1_r <= alloc1_nxt;
      if (wr_a2) alloc2_r <= alloc2_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'h1;
    case (s_axi_araddr)
      ADDR_W'(`SIMF_OFS_CTRL):   rd_data[`SIMF_F_METHOD +: 4] = method_r;
      ADDR_W'(`SIMF_OFS_ALLOC1): rd_data[15:0] = alloc1_r;
      ADDR_W'(`SIMF_OFS_ALLOC2): rd_data[15:0] = alloc2_r;
      ADDR_W'(`SIMF_OFS_STATUS): begin
        rd_data[`SIMF_S_BASEBLOCK] = ~current_enable;
        rd_data[`SIMF_S_MONITOR]   = safety_monitor_out;
        rd_data[`SIMF_S_SAFE_A]    = pins_s.safe_a;
        rd_data[`SIMF_S_SAFE_B]    = pins_s.safe_b;
        rd_data[`SIMF_S_PINS +: 7] = pins_s.seq;
        rd_data[`SIMF_S_FUNC +: $bits(simf_pkg::simf_func_t)] = func_out;
      end
      default: rd_ok = 1'h0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'h1;
      s_axi_rvalid  <= 1'h0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SIMF_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid  <= 1'h1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_ok ? `SIMF_RESP_OKAY : `SIMF_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'h0;
      s_axi_arready <= 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  AST_BASEBLOCK_CUT: assert property (
    (!pins_s.safe_a || !pins_s.safe_b) |=> !current_enable)
    else $error("Current not cut with a safety input OFF");
  AST_MONITOR_ON: assert property (
    rst_b |=> (safety_monitor_out == $past(!pins_s.safe_a && !pins_s.safe_b)))
    else $error("Monitor output does not follow baseblock");
  AST_ALLOC_KEPT: assert property (
    $changed(method_r) |-> ($stable(alloc1_r) && $stable(alloc2_r)))
    else $error("Method change altered the allocation");
  AST_METHOD_012: assert property (
    (method_r <= 4'h2) |=> (func_out.proportional_op_in == $past(s41)
      && func_out.fwd_force_limit_in == $past(s45) && !func_out.int_speed_sel_a))
    else $error("Methods 0-2 pin 41/45 mapping wrong");
  AST_METHOD_3: assert property (
    (method_r == 4'h3) |=> (func_out.move_direction_sel == $past(s41)
      && func_out.int_speed_sel_a == $past(s45) && !func_out.fwd_force_limit_in))
    else $error("Method 3 mapping wrong");
  AST_METHOD_456: assert property (
    (method_r inside {4'h4, 4'h5, 4'h6}) |=> (func_out.int_speed_sel_b == $past(s46)
      && !func_out.proportional_op_in))
    else $error("Methods 4-6 mapping wrong");
  AST_METHOD_789: assert property (
    (method_r inside {4'h7, 4'h8, 4'h9}) |=> (func_out.ctrl_switch == $past(s41)
      && func_out.rev_force_limit_in == $past(s46)))
    else $error("Methods 7-9 mapping wrong");
  AST_METHOD_A: assert property (
    (method_r == 4'hA) |=> (func_out.zero_clamp_in == $past(s41) && !func_out.ctrl_switch))
    else $error("Method A zero clamp mapping wrong");
  AST_METHOD_B: assert property (
    (method_r == 4'hB) |=> (func_out.pulse_inhibit == $past(s41) && !func_out.zero_clamp_in))
    else $error("Method B inhibit mapping wrong");
  AST_FIXED_PINS: assert property (
    (alloc2_r[`SIMF_F_ALM +: 4] == 4'h4) |=> (func_out.alarm_clear_in == $past(pins_s.seq[4])))
    else $error("Alarm clear not on pin 44");
  AST_ALLOC_READ: assert property (
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_W'(`SIMF_OFS_ALLOC2))
      |=> (s_axi_rvalid && s_axi_rdata[15:0] == $past(alloc2_r)))
    else $error("Allocation group 2 read back wrong");
  AST_ALLOC_LOCK: assert property (
    !user_mode |=> ($stable(alloc2_r) && $stable(alloc1_r[15:`SIMF_F_SON])))
    else $error("Allocation changed outside user mode");
  AST_FORCE_ON: assert property (
    (alloc1_r[`SIMF_F_SON +: 4] == `SIMF_ALLOC_ON) |=> func_out.servo_on)
    else $error("Forced-on servo enable not active");
  AST_FORCE_OFF: assert property (
    (alloc1_r[`SIMF_F_SON +: 4] == `SIMF_ALLOC_OFF) |=> !func_out.servo_on)
    else $error("Forced-off servo enable active");
  AST_ONE_EDGE: assert property (
    ($changed(method_r) && method_r == 4'h3) |=> (func_out.move_direction_sel == $past(s41)))
    else $error("Method change took more than one edge");

  COV_BASEBLOCK: cover property (current_enable ##1 !current_enable ##1 safety_monitor_out);
  COV_SPEED_SEL: cover property (method_r == 4'h3 && func_out.int_speed_sel_a);
  COV_USER_WRITE: cover property (user_mode && do_write && wr_a2);
  COV_STATUS_READ: cover property (s_axi_rvalid && s_axi_rready && s_axi_rdata[1]);

endmodule : simf_top

// >>> testbench/simf_host_model.sv
// Host controller and safety device driving the input pins
`timescale 1ns/1ps
module simf_host_model (
  // Clock
  input  wire logic       clock,
  // Commanded levels
  input  wire logic [6:0] cmd_seq,
  input  wire logic       cmd_a,
  input  wire logic       cmd_b,
  // Pins
  output logic      [6:0] seq_pin_on,
  output logic            safety_block_in_a,
  output logic            safety_block_in_b
);
  initial begin
    seq_pin_on = 7'h00;
    safety_block_in_a = 1'b0;
    safety_block_in_b = 1'b0;
  end
  // Pins move away from the sampling edge
  always @(negedge clock) begin
    seq_pin_on        <= cmd_seq;
    safety_block_in_a <= cmd_a;
    safety_block_in_b <= cmd_b;
  end
endmodule : simf_host_model

// >>> testbench/tb.sv
// Self-checking testbench of the input function mux
`timescale 1ns/1ps
`include "simf_defines.svh"
module tb;
  logic                 clock = 1'b0;
  logic                 rst_b;
  logic [6:0]           cmd_seq;
  logic                 cmd_a;
  logic                 cmd_b;
  logic [6:0]           pins;
  logic                 safe_a;
  logic                 safe_b;
  logic                 cur_en;
  logic                 mon;
  simf_pkg::simf_func_t fo;
  logic [7:0]           awaddr;
  logic [7:0]           araddr;
  logic [31:0]          wdata;
  logic [31:0]          rdata;
  logic                 awvalid, awready, wvalid, wready, bvalid, bready;
  logic                 arvalid, arready, rvalid, rready;
  logic [1:0]           bresp;
  logic [1:0]           rresp;
  logic [12:0]          ef;
  int                   n_errors = 0;
  int                   num_checks = 0;

  always #2 clock = ~clock;

  simf_host_model host (.clock(clock), .cmd_seq(cmd_seq), .cmd_a(cmd_a), .cmd_b(cmd_b),
    .seq_pin_on(pins), .safety_block_in_a(safe_a), .safety_block_in_b(safe_b));

  simf_top uut (.clock(clock), .rst_b(rst_b), .seq_pin_on(pins),
    .safety_block_in_a(safe_a), .safety_block_in_b(safe_b), .current_enable(cur_en),
    .safety_monitor_out(mon), .func_out(fo), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task automatic conclude();
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_d, w_d, done;
    int   t;
    aw_d = 1'b0; w_d = 1'b0; done = 1'b0; t = 0;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clock);
      t++;
      if (aw_d && w_d && bvalid === 1'b1) done = 1'b1;
      if (!aw_d && awready === 1'b1) begin aw_d = 1'b1; awvalid <= 1'b0; end
      if (!w_d && wready === 1'b1) begin w_d = 1'b1; wvalid <= 1'b0; end
    end while (!done && t < 50);
    if (!done) n_errors++;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr_chk

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    int   t;
    done = 1'b0; t = 0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clock);
      t++;
      if (!arvalid && rvalid === 1'b1) done = 1'b1;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (!done && t < 50);
    if (!done) n_errors++;
    chk("rdata", ed, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rd_chk

  function automatic logic [12:0] efn(input logic [3:0] m, input logic [6:0] p);
    logic [12:0] f;
    f = {p[0], p[2], p[3], p[4], 9'h000};
    if (m <= 4'h2 || m > 4'hB) f[8:6] = {p[1], p[5], p[6]};
    else if (m <= 4'h6) f[5:3] = {p[1], p[5], p[6]};
    else begin
      f[7:6] = {p[5], p[6]};
      if (m <= 4'h9) f[2] = p[1];
      else if (m == 4'hA) f[1] = p[1];
      else f[0] = p[1];
    end
    return f;
  endfunction : efn

  initial begin
    #100000;
    n_errors++;
    conclude();
  end

  initial begin
    rst_b = 1'b0; cmd_seq = 7'h00; cmd_a = 1'b1; cmd_b = 1'b1;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    cyc(12);
    rst_b <= 1'b1;
    cyc(1);
    // ----------------------------------------------------------------
    // Reset values and unmapped place
    // ----------------------------------------------------------------
    rd_chk(`SIMF_OFS_ALLOC1, 32'h0000_2100, `SIMF_RESP_OKAY);
    rd_chk(`SIMF_OFS_ALLOC2, 32'h0000_6543, `SIMF_RESP_OKAY);
    rd_chk(8'h10, 32'h0000_0000, `SIMF_RESP_SLVERR);
    wr_chk(8'h10, 32'h0000_0005, `SIMF_RESP_SLVERR);
    // ----------------------------------------------------------------
    // Safety channels
    // ----------------------------------------------------------------
    for (int i = 0; i < 4; i++) begin
      {cmd_a, cmd_b} <= i[1:0];
      cyc(6);
      chk("current", {31'h0, i == 3}, {31'h0, cur_en});
      chk("monitor", {31'h0, i == 0}, {31'h0, mon});
    end
    // ----------------------------------------------------------------
    // Every control method, two pin patterns
    // ----------------------------------------------------------------
    for (int m = 0; m < 12; m++) begin
      wr_chk(`SIMF_OFS_CTRL, m, `SIMF_RESP_OKAY);
      for (int k = 0; k < 2; k++) begin
        cmd_seq <= k ? 7'h5D : 7'h22;
        cyc(6);
        chk("func", {19'h0, efn(m[3:0], pins)}, {19'h0, fo});
      end
    end
    rd_chk(`SIMF_OFS_ALLOC1, 32'h0000_2100, `SIMF_RESP_OKAY);
    rd_chk(`SIMF_OFS_CTRL, 32'h0000_000B, `SIMF_RESP_OKAY);
    wr_chk(`SIMF_OFS_CTRL, 32'h0000_0000, `SIMF_RESP_OKAY);
    // ----------------------------------------------------------------
    // Allocation mode and forced codes
    // ----------------------------------------------------------------
    wr_chk(`SIMF_OFS_ALLOC1, 32'h0000_2171, `SIMF_RESP_OKAY);
    rd_chk(`SIMF_OFS_ALLOC1, 32'h0000_2101, `SIMF_RESP_OKAY);
    wr_chk(`SIMF_OFS_ALLOC1, 32'h0000_2171, `SIMF_RESP_OKAY);
    rd_chk(`SIMF_OFS_ALLOC1, 32'h0000_2171, `SIMF_RESP_OKAY);
    cmd_seq <= 7'h00;
    cyc(6);
    chk("func", {19'h0, efn(4'h0, 7'h00) | 13'h1000}, {19'h0, fo});
    wr_chk(`SIMF_OFS_ALLOC1, 32'h0000_2181, `SIMF_RESP_OKAY);
    cmd_seq <= 7'h7F;
    cyc(6);
    ef = efn(4'h0, 7'h7F) & 13'h0FFF;
    chk("func", {19'h0, ef}, {19'h0, fo});
    rd_chk(`SIMF_OFS_STATUS, {3'h0, ef, 1'b0, 7'h7F, 8'h0C}, `SIMF_RESP_OKAY);
    conclude();
  end
endmodule : tb
